// [common/timer_map.vh]
// register offsets, field positions, reset values and counts for the timer
`ifndef TIMER_MAP_VH
`define TIMER_MAP_VH

// register byte offsets on the apb bus
`define OFS_TIMER_CONTROL   8'h00
`define OFS_COUNTER_PRELOAD 8'h04
`define OFS_COUNT           8'h08
`define OFS_STATUS          8'h0C
`define OFS_PORT_C_DATA     8'h10
`define OFS_PORT_C_DIR      8'h14
`define OFS_IRQ_VECTOR      8'h18

// timer control fields
`define TC_ENABLE_BIT       0
`define TC_CLK_LSB          1
`define TC_CLK_MSB          2
`define TC_ZD_BIT           4
`define TC_OUT_LSB          5
`define TC_OUT_MSB          7

// clock control encodings
`define CLK_SYS_PRE         2'h0
`define CLK_SYS_PRE_GATE    2'h1
`define CLK_TIN_PRE         2'h2
`define CLK_TIN_DIRECT      2'h3

// status and port c fields
`define ST_ZD_BIT           0
`define PORT_C_TIMER_BIT    3

// reset values and count constants
`define TIMER_CONTROL_RST   8'h00
`define IRQ_VECTOR_RST      8'h0F
`define PRESCALE_ALL_ONES   5'h1F
`define COUNT_ONE           24'h000001
`define COUNT_ZERO          24'h000000

`endif

// [design/pin_sync.v]
// two-stage synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
    parameter WIDTH = 3
) (
    input  wire             ref_clk,
    input  wire             rst,
    input  wire [WIDTH-1:0] pin_async,
    output reg  [WIDTH-1:0] pin_sync_q
);

    reg [WIDTH-1:0] meta;

    // first stage feeds only the second stage
    always @(posedge ref_clk) begin
        if (rst) begin
            meta       <= {WIDTH{1'b0}};
            pin_sync_q <= {WIDTH{1'b0}};
        end else begin
            meta       <= pin_async;
            pin_sync_q <= meta;
        end
    end

endmodule // pin_sync

`default_nettype wire

// [design/timer_application_modes.v]
// 24-bit down-counting timer with prescaler and apb register slave
//
// Contract
// - interrupt mode: count step one to zero sets zero flag, raises output if request enabled
// - reload mode: next counter clock after zero loads preload, then counts
// - square wave mode: output toggles and zero flag sets at each zero
// - host reads present timer output level through port c data
// - after reset the output pin acts as port c bit 3
// - square wave output is held high while timer is disabled
// - zero-detect control set: counter wraps past zero, keeps counting
// - acknowledge gets no answer unless an interrupt request is active
// - acknowledge on active request with mode bit 6 clear drives vector and transfer acknowledge
// - system clock selection lets timer input gate counting
// - external clock selection counts timer input pulses while running
// - watchdog: once enabled, timer input level picks run or halt
// - watchdog: input going high loads preload and starts counting
// - watchdog: input falling before zero keeps output and flag low
// - watchdog: zero while input high sets flag, output, counter wraps
// - watchdog: input falling clears flag, output, stops, prescaler ones
// - zero flag stays set until host clears it or the timer halts
// - halt keeps count, forces prescaler to all ones, flag to zero
// - prescaled: first wrap after run loads preload, then acts per wrap
// - reset clears all control bits, pins to port c, timer halts
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "timer_map.vh"

module timer_application_modes (
    input  wire        ref_clk,
    input  wire        rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        timer_input_pin,
    input  wire        timer_irq_ack_pin,
    input  wire        port_c_bit3_in,
    output wire        timer_output_pin,
    output wire        timer_output_oe,
    output reg  [7:0]  irq_vector_data,
    output reg         transfer_ack
);

    // run/halt states, one-hot
    localparam ST_HALT = 2'b01;
    localparam ST_RUN  = 2'b10;

    reg  [7:0]  timer_control;
    reg  [23:0] counter_preload;
    reg  [23:0] count;
    reg  [4:0]  prescale;
    reg         zero_detect_flag;
    reg         loaded;
    reg         square_level;
    reg         port_c_data3;
    reg         port_c_dir3;
    reg  [7:0]  vector_reg;
    reg  [1:0]  state;
    reg  [1:0]  next_state;
    reg         tin_d;
    reg  [31:0] read_mux;
    wire [2:0]  sync_q;
    wire        tin_s;
    wire        ack_s;
    wire        pc3_s;
    wire [2:0]  out_mode;
    wire [1:0]  clk_ctl;
    wire        enable;
    wire        zd_ctrl;
    wire        timer_mode;
    wire        irq_active;
    wire        timer_irq_ack_pin_used;
    wire        timer_level;
    wire        run_ok;
    wire        in_run;
    wire        tin_rise;
    wire        use_pre;
    wire        src_tick;
    wire        pre_wrap;
    wire        cnt_tick;
    wire        zero_step;
    wire        wr;
    wire        rd_setup;

    // address decode, used only by the error answer
    function addr_mapped;
        input [7:0] a;
        begin
            addr_mapped = (a == `OFS_TIMER_CONTROL)   ||
                          (a == `OFS_COUNTER_PRELOAD) ||
                          (a == `OFS_COUNT)           ||
                          (a == `OFS_STATUS)          ||
                          (a == `OFS_PORT_C_DATA)     ||
                          (a == `OFS_PORT_C_DIR)      ||
                          (a == `OFS_IRQ_VECTOR);
        end
    endfunction

    // output-mode decode: 00x port c, 01x square wave, 1xx interrupt
    function is_irq_mode;
        input [2:0] m;
        begin
            is_irq_mode = m[2];
        end
    endfunction

    function is_square;
        input [2:0] m;
        begin
            is_square = (m[2:1] == 2'b01);
        end
    endfunction

    // timer input, acknowledge and port pin come from outside the clock
    pin_sync #(
        .WIDTH (3)
    ) u_pin_sync (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .pin_async  ({port_c_bit3_in, timer_irq_ack_pin, timer_input_pin}),
        .pin_sync_q (sync_q)
    );

    assign tin_s = sync_q[0];
    assign ack_s = sync_q[1];
    assign pc3_s = sync_q[2];

    // control field decode
    assign out_mode   = timer_control[`TC_OUT_MSB:`TC_OUT_LSB];
    assign clk_ctl    = timer_control[`TC_CLK_MSB:`TC_CLK_LSB];
    assign enable     = timer_control[`TC_ENABLE_BIT];
    assign zd_ctrl    = timer_control[`TC_ZD_BIT];
    assign timer_mode = is_irq_mode(out_mode) | is_square(out_mode);

    // request follows the flag; low bit of mode enables the request
    assign irq_active = is_irq_mode(out_mode) & out_mode[0]
                        & zero_detect_flag;
    // acknowledge pin serves the timer only when mode bit 6 is clear
    assign timer_irq_ack_pin_used = is_irq_mode(out_mode) & ~out_mode[1];
    assign timer_level = is_square(out_mode) ? square_level
                                             : irq_active;

    // pin: port c bit 3 until a timer mode is programmed
    assign timer_output_pin = timer_mode ? timer_level
                                         : port_c_data3;
    assign timer_output_oe  = timer_mode | port_c_dir3;

    // gated clock selection lets the input level decide run or halt
    assign run_ok = enable & ((clk_ctl != `CLK_SYS_PRE_GATE)
                              | tin_s);
    assign in_run = (state == ST_RUN);

    // counter clock sources
    assign tin_rise = tin_s & ~tin_d;
    assign use_pre  = (clk_ctl != `CLK_TIN_DIRECT);
    assign src_tick = clk_ctl[1] ? tin_rise : 1'b1;
    assign pre_wrap = in_run & use_pre & src_tick
                      & (prescale == 5'h00);
    assign cnt_tick = use_pre ? pre_wrap
                              : (in_run & tin_rise);
    assign zero_step = cnt_tick & loaded & (count == `COUNT_ONE);

    // apb strobes; zero wait states
    assign wr       = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & ~addr_mapped(paddr);

    // run/halt state machine
    always @* begin
        case (state)
            ST_HALT: next_state = run_ok ? ST_RUN : ST_HALT;
            ST_RUN:  next_state = run_ok ? ST_RUN : ST_HALT;
            default: next_state = ST_HALT;
        endcase
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            state <= ST_HALT;
            tin_d <= 1'b0;
        end else begin
            state <= next_state;
            tin_d <= tin_s;
        end
    end

    // control registers; reset returns pins to port c inputs
    always @(posedge ref_clk) begin
        if (rst) begin
            timer_control <= `TIMER_CONTROL_RST;
            port_c_data3  <= 1'b0;
            port_c_dir3   <= 1'b0;
            vector_reg    <= `IRQ_VECTOR_RST;
        end else if (wr && pstrb[0]) begin
            if (paddr == `OFS_TIMER_CONTROL)
                timer_control <= pwdata[7:0];
            if (paddr == `OFS_PORT_C_DATA)
                port_c_data3 <= pwdata[`PORT_C_TIMER_BIT];
            if (paddr == `OFS_PORT_C_DIR)
                port_c_dir3 <= pwdata[`PORT_C_TIMER_BIT];
            if (paddr == `OFS_IRQ_VECTOR)
                vector_reg <= pwdata[7:0];
        end
    end

    // preload bytes, one lane each; reset leaves the preload untouched
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_preload
            always @(posedge ref_clk) begin
                if (wr && pstrb[g] && paddr == `OFS_COUNTER_PRELOAD)
                    counter_preload[8*g+7:8*g] <= pwdata[8*g+7:8*g];
            end
        end
    endgenerate

    // prescaler: held at all ones outside run
    always @(posedge ref_clk) begin
        if (rst || !in_run)
            prescale <= `PRESCALE_ALL_ONES;
        else if (use_pre && src_tick)
            prescale <= prescale - 5'h01;  // 00 wraps to 1F
    end

    // counter: first tick after run loads, then reload or wrap at zero
    always @(posedge ref_clk) begin
        if (rst || !in_run) begin
            loaded <= 1'b0;    // count itself is kept in halt
        end else if (cnt_tick) begin
            if (!loaded) begin
                count  <= counter_preload;
                loaded <= 1'b1;
            end else if (count == `COUNT_ZERO && !zd_ctrl) begin
                count <= counter_preload;
            end else begin
                count <= count - `COUNT_ONE;
            end
        end
    end

    // zero flag: sticky, set wins over a clear in the same cycle
    always @(posedge ref_clk) begin
        if (rst || !in_run)
            zero_detect_flag <= 1'b0;
        else if (zero_step)
            zero_detect_flag <= 1'b1;
        else if (wr && pstrb[0] && paddr == `OFS_STATUS
                 && pwdata[`ST_ZD_BIT])
            zero_detect_flag <= 1'b0;
    end

    // square wave level: high until enabled, then toggles at zero
    always @(posedge ref_clk) begin
        if (rst || !enable)
            square_level <= 1'b1;
        else if (zero_step && is_square(out_mode))
            square_level <= ~square_level;
    end

    // acknowledge answered only for a live request on a vectored pin
    always @(posedge ref_clk) begin
        if (rst) begin
            transfer_ack    <= 1'b0;
            irq_vector_data <= 8'h00;
        end else if (ack_s && timer_irq_ack_pin_used && irq_active) begin
            transfer_ack    <= 1'b1;
            irq_vector_data <= vector_reg;
        end else begin
            transfer_ack    <= 1'b0;
            irq_vector_data <= 8'h00;
        end
    end

    // read mux; count is not latched, but a run-state read takes all 24 bits at one edge
    always @* begin
        read_mux = 32'h0000_0000;
        case (paddr)
            `OFS_TIMER_CONTROL:   read_mux[7:0]  = timer_control;
            `OFS_COUNTER_PRELOAD: read_mux[23:0] = counter_preload;
            `OFS_COUNT:           read_mux[23:0] = count;
            `OFS_STATUS:
                read_mux[`ST_ZD_BIT] = zero_detect_flag;
            `OFS_PORT_C_DATA:
                read_mux[`PORT_C_TIMER_BIT] =
                    timer_mode  ? timer_level :
                    port_c_dir3 ? port_c_data3 : pc3_s;
            `OFS_PORT_C_DIR:
                read_mux[`PORT_C_TIMER_BIT] = port_c_dir3;
            `OFS_IRQ_VECTOR:      read_mux[7:0]  = vector_reg;
            default:              read_mux = 32'h0000_0000;
        endcase
    end

    // read data captured in setup so it is stable in the access phase
    always @(posedge ref_clk) begin
        if (rst)
            prdata <= 32'h0000_0000;
        else if (rd_setup)
            prdata <= read_mux;
    end

endmodule // timer_application_modes

`default_nettype wire

// [bench/timer_application_modes_asserts.sv]
// checker on the timer ports: apb answers, acknowledge, reset state
`timescale 1ns/1ns
`default_nettype none
module timer_checker (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        timer_irq_ack_pin,
    input wire logic        timer_output_pin,
    input wire logic        timer_output_oe,
    input wire logic [7:0]  irq_vector_data,
    input wire logic        transfer_ack
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    chk_reset_port: assert property (
        $past(rst) |-> !timer_output_oe && !timer_output_pin && !transfer_ack)
        else $error("pin not back to port state after reset");
    chk_ack_cause: assert property (
        $rose(transfer_ack) |-> $past(timer_irq_ack_pin, 3) && timer_output_pin)
        else $error("transfer ack without acknowledge and request");
    chk_ack_release: assert property (
        !timer_irq_ack_pin [*4] |-> !transfer_ack)
        else $error("transfer ack held after acknowledge ended");
    chk_vector_idle: assert property (
        !transfer_ack |-> irq_vector_data == 8'h00)
        else $error("vector driven without transfer ack");
    chk_ack_no_req: assert property (
        transfer_ack && !timer_output_pin |=> !transfer_ack)
        else $error("transfer ack kept after request withdrawn");
    chk_unmapped_err: assert property (
        psel && penable && paddr > 8'h18 |-> pslverr)
        else $error("unmapped access without error");
    chk_mapped_ok: assert property (
        psel && penable && paddr <= 8'h18 && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("error on mapped access");
    chk_read_holds: assert property (
        !(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved outside read setup");
endmodule // timer_checker
bind timer_application_modes timer_checker u_chk (.ref_clk, .rst, .psel,
    .penable, .pwrite, .paddr, .prdata, .pslverr, .timer_irq_ack_pin,
    .timer_output_pin, .timer_output_oe, .irq_vector_data, .transfer_ack);
`default_nettype wire

// [bench/timer_pin_env.sv]
// model of the pin circuitry around the timer
`timescale 1ns/1ns
`default_nettype none
module timer_pin_env (
    input  wire logic       ref_clk,
    input  wire logic       timer_output_pin,
    input  wire logic       timer_output_oe,
    input  wire logic       transfer_ack,
    input  wire logic [7:0] irq_vector_data,
    output var  logic       timer_input_pin,
    output var  logic       timer_irq_ack_pin,
    output wire logic       port_c_bit3_in
);
    // pull-up keeps the shared pin high while nobody drives it
    assign port_c_bit3_in = timer_output_oe ? timer_output_pin : 1'b1;
    initial begin
        timer_input_pin = 1'b0;
        timer_irq_ack_pin = 1'b0;
    end
    // gate or count input, changed just after an edge
    task automatic set_in(input logic v);
        @(posedge ref_clk) timer_input_pin <= v;
    endtask
    // acknowledge held until answered, ten clocks at most
    task automatic ack(output logic got, output logic [7:0] vec);
        int k;
        @(posedge ref_clk) timer_irq_ack_pin <= 1'b1;
        for (k = 0; k < 10 && transfer_ack !== 1'b1; k++) @(posedge ref_clk);
        got = transfer_ack;
        vec = irq_vector_data;
        timer_irq_ack_pin <= 1'b0;
        repeat (6) @(posedge ref_clk);
    endtask
endmodule // timer_pin_env
`default_nettype wire

// [bench/timer_application_modes_tb_top.sv]
// self-checking bench: apb tasks, timer mode sequences, verdict
`timescale 1ns/1ns
`default_nettype none
`include "timer_map.vh"
module timer_application_modes_tb_top;
    logic        ref_clk, rst, psel, penable, pwrite, err, got;
    logic [7:0]  paddr, gotv, irq_vector_data;
    logic [31:0] pwdata, prdata, rd, cnt;
    logic        pready, pslverr, timer_input_pin, timer_irq_ack_pin;
    logic        port_c_bit3_in, timer_output_pin, timer_output_oe;
    logic        transfer_ack;
    logic [3:0]  pstrb, lanes;
    int          n_fail = 0;
    int          num_checks = 0;
    timer_application_modes u_dut (.ref_clk, .rst, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
        .timer_input_pin, .timer_irq_ack_pin, .port_c_bit3_in,
        .timer_output_pin, .timer_output_oe, .irq_vector_data, .transfer_ack);
    timer_pin_env env (.ref_clk, .timer_output_pin, .timer_output_oe,
        .transfer_ack, .irq_vector_data, .timer_input_pin, .timer_irq_ack_pin,
        .port_c_bit3_in);
    // 125 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    task automatic check(input string what, input logic [31:0] exp, v);
        num_checks++;
        if (v !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, v);
        end
    endtask
    // one apb transfer; never assumes the wait count
    // only the watchdog ends a wait for pready
    task automatic apb(input logic w, input logic [7:0] a, input int d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= lanes;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_pin(input logic v, input int lim);
        for (int k = 0; k < lim && timer_output_pin !== v; k++)
            @(posedge ref_clk);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // watchdog: whole run is about a thousand clocks
    initial begin
        #400000;
        n_fail++;
        end_of_test;
    end
    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
        pstrb = 4'h0;
        lanes = 4'hF;
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        apb(0, `OFS_TIMER_CONTROL, 0);
        check("control", `TIMER_CONTROL_RST, rd);
        check("oe", 0, timer_output_oe);
        apb(0, `OFS_IRQ_VECTOR, 0);
        check("vector reg", `IRQ_VECTOR_RST, rd);
        check("no err", 0, err);
        apb(1, `OFS_IRQ_VECTOR, 32'hA5);
        apb(0, 8'h40, 0);
        check("slverr", 1, err);
        // port c bit 3 as output, then as input on the pull-up
        apb(1, `OFS_PORT_C_DIR, 32'h8);
        apb(1, `OFS_PORT_C_DATA, 32'h8);
        apb(0, `OFS_PORT_C_DATA, 0);
        check("pc data", 32'h8, rd);
        check("pc oe", 1, timer_output_oe);
        check("pc pin", 1, timer_output_pin);
        apb(1, `OFS_PORT_C_DATA, 0);
        apb(0, `OFS_PORT_C_DATA, 0);
        check("pc low", 0, rd);
        check("pc pin low", 0, timer_output_pin);
        apb(1, `OFS_PORT_C_DIR, 0);
        repeat (4) @(posedge ref_clk);
        apb(0, `OFS_PORT_C_DATA, 0);
        check("pc in", 32'h8, rd);
        check("pc oe off", 0, timer_output_oe);
        env.ack(got, gotv);
        check("ack port", 0, got);
        $display("reset test done");
        // periodic interrupt, reload on zero
        apb(1, `OFS_COUNTER_PRELOAD, 2);
        apb(1, `OFS_TIMER_CONTROL, 32'hA1);
        env.ack(got, gotv);
        check("ack idle", 0, got);
        wait_pin(1, 200);
        check("irq pin", 1, timer_output_pin);
        env.ack(got, gotv);
        check("ack", 1, got);
        check("vector", 8'hA5, gotv);
        apb(0, `OFS_STATUS, 0);
        check("flag held", 1, rd);
        apb(1, `OFS_STATUS, 1);
        apb(0, `OFS_STATUS, 0);
        check("flag clear", 0, rd);
        check("irq off", 0, timer_output_pin);
        wait_pin(1, 120);
        check("reloaded", 1, timer_output_pin);
        apb(1, `OFS_TIMER_CONTROL, 32'hA0);
        apb(0, `OFS_COUNT, 0);
        cnt = rd;
        repeat (64) @(posedge ref_clk);
        apb(0, `OFS_COUNT, 0);
        check("count held", cnt, rd);
        apb(0, `OFS_STATUS, 0);
        check("halt flag", 0, rd);
        $display("periodic test done");
        // square wave, then wrap on zero
        apb(1, `OFS_TIMER_CONTROL, 32'h40);
        apb(0, `OFS_PORT_C_DATA, 0);
        check("sq idle", 32'h8, rd);
        apb(1, `OFS_TIMER_CONTROL, 32'h41);
        wait_pin(0, 200);
        check("sq toggle", 0, timer_output_pin);
        apb(0, `OFS_PORT_C_DATA, 0);
        check("sq level", 0, rd);
        apb(0, `OFS_STATUS, 0);
        check("sq flag", 1, rd);
        apb(1, `OFS_TIMER_CONTROL, 32'h50);
        apb(1, `OFS_TIMER_CONTROL, 32'h51);
        wait_pin(0, 200);
        repeat (36) @(posedge ref_clk);
        apb(1, `OFS_TIMER_CONTROL, 32'h50);
        apb(0, `OFS_COUNT, 0);
        check("wrap", 32'hFFFFFF, rd);
        $display("square test done");
        // watchdog on the gate input
        apb(1, `OFS_TIMER_CONTROL, 32'hB3);
        env.set_in(1);
        repeat (40) @(posedge ref_clk);
        env.set_in(0);
        repeat (150) @(posedge ref_clk);
        apb(0, `OFS_STATUS, 0);
        check("wd early", 0, rd);
        check("wd pin", 0, timer_output_pin);
        env.set_in(1);
        wait_pin(1, 200);
        apb(0, `OFS_STATUS, 0);
        check("wd late", 1, rd);
        env.set_in(0);
        repeat (8) @(posedge ref_clk);
        check("wd off", 0, timer_output_pin);
        apb(0, `OFS_STATUS, 0);
        check("wd flag", 0, rd);
        // direct count of input pulses
        apb(1, `OFS_COUNTER_PRELOAD, 5);
        apb(1, `OFS_TIMER_CONTROL, 32'h17);
        repeat (4) begin
            env.set_in(1);
            repeat (4) @(posedge ref_clk);
            env.set_in(0);
            repeat (8) @(posedge ref_clk);
        end
        apb(1, `OFS_TIMER_CONTROL, 32'h16);
        apb(0, `OFS_COUNT, 0);
        check("pulses", 2, rd);
        // low byte lane only: upper preload bytes keep their value
        lanes = 4'h1;
        apb(1, `OFS_COUNTER_PRELOAD, 32'h00FFFF07);
        lanes = 4'hF;
        apb(0, `OFS_COUNTER_PRELOAD, 0);
        check("lanes", 32'h7, rd);
        $display("watchdog and count test done");
        end_of_test;
    end
endmodule // timer_application_modes_tb_top
`default_nettype wire
